// ### logic/sarseq_defines.vh
`ifndef SARSEQ_DEFINES_VH
`define SARSEQ_DEFINES_VH
// ----------------------------------------
// widths and codes
// ----------------------------------------
`define SARSEQ_BITS        16
`define SARSEQ_CODE_ZERO   16'h0000
`define SARSEQ_CODE_MID    16'h8000
`define SARSEQ_CODE_FULL   16'hffff
// ----------------------------------------
// timing
// ----------------------------------------
`define SARSEQ_CLK_HZ      50000000
`define SARSEQ_RATE_SPS    500000
// sample period in system cycles (least period, rounded down is exact here)
`define SARSEQ_PERIOD_CYC  (`SARSEQ_CLK_HZ / `SARSEQ_RATE_SPS)
// conversion clock divider: one trial step per this many cycles
`define SARSEQ_STEP_DIV    4
// settle cycles after sampling switches open
`define SARSEQ_SETTLE_CYC  2
`endif

// ### logic/sarseq_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a vector of pin levels
module sarseq_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst,
   // level in and out
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   // meta feeds only q
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= {W{1'b0}};
         q    <= {W{1'b0}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // sarseq_sync
`default_nettype wire

// ### logic/sarseq_top.v
// What this block does
// - a rising edge on the convert input ends acquisition and starts a conversion.
// - the two sampling switches open first, before any trial step.
// - the result is found by 16 binary-weighted trial steps, most significant bit first.
// - after the last step the block returns to acquisition, latches the code and flags completion.
// - steps are timed from an internal divider, never from the serial clock.
// - the result is 16-bit straight binary from 0000 to ffff with midscale at 8000.
// - an input over the top of the range gives all ones, never a wrapped code.
// - an input under the bottom of the range gives all zeros.
// - the block powers down by itself at the end of every conversion.
// - conversion fits within a 500 kSPS period and the code is ready with no pipeline delay.
// - mode select low at the convert edge picks chain mode, high picks select mode.
// - a started conversion runs to completion whatever the convert input does.
// - when selected, the result shifts out on the serial output in step with the serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defines.vh"
module sarseq_top #(
   parameter BITS     = `SARSEQ_BITS,
   parameter STEP_DIV = `SARSEQ_STEP_DIV
) (
   // clock and reset
   input  wire            SYS_CLK,
   input  wire            RST,
   // host pins
   input  wire            CONVERT_START,
   input  wire            MODE_SELECT_INPUT,
   input  wire            SERIAL_CLK,
   output reg             SERIAL_RESULT_OUT,
   output reg             SERIAL_RESULT_OE_N,
   // analog front end
   input  wire            COMP_HIGH,
   input  wire            OVER_RANGE,
   input  wire            UNDER_RANGE,
   output reg             POS_SAMPLE_SWITCH,
   output reg             NEG_SAMPLE_SWITCH,
   output reg  [BITS-1:0] DAC_TRIAL,
   output reg             POWER_DOWN,
   // status
   output reg             BUSY,
   output reg  [BITS-1:0] RESULT_CODE,
   output reg             CHAIN_MODE
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_ACQ    = 2'd0;
   localparam ST_SETTLE = 2'd1;
   localparam ST_TRIAL  = 2'd2;
   localparam ST_DONE   = 2'd3;
   localparam CNT_W     = 5;
   localparam DIV_W     = 4;

   wire          cnv_s;
   wire          msel_s;
   wire          sck_s;
   reg           cnv_d;
   reg           sck_d;
   reg  [1:0]    state;
   reg  [CNT_W-1:0] step;
   reg  [DIV_W-1:0] div;
   reg  [BITS-1:0]  work;
   reg  [BITS-1:0]  shreg;
   reg  [CNT_W-1:0] shcnt;
   reg           step_en;
   wire          cnv_rise;
   wire          sck_fall;
   wire          cnv_fall;

   // pins come from outside this clock
   sarseq_sync #(
      .W (3)
   ) u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .d   ({CONVERT_START, MODE_SELECT_INPUT, SERIAL_CLK}),
      .q   ({cnv_s, msel_s, sck_s})
   );

   assign cnv_rise = cnv_s & ~cnv_d;
   assign cnv_fall = ~cnv_s & cnv_d;
   assign sck_fall = ~sck_s & sck_d;

   // ----------------------------------------
   // conversion clock divider
   // ----------------------------------------
   // internal divider, held at zero in acquisition, so step timing never depends on the serial clock
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         div     <= {DIV_W{1'b0}};
         step_en <= 1'b0;
      end else if (state == ST_ACQ) begin
         div     <= {DIV_W{1'b0}};
         step_en <= 1'b0;
      end else begin
         step_en <= (div == STEP_DIV[DIV_W-1:0] - 4'd1);
         div     <= (div == STEP_DIV[DIV_W-1:0] - 4'd1) ? {DIV_W{1'b0}} : div + 4'd1;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // 2 settle + 16*4 steps = well under the 100-cycle 500 kSPS period
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state             <= ST_ACQ;
         cnv_d             <= 1'b0;
         sck_d             <= 1'b0;
         step              <= {CNT_W{1'b0}};
         work              <= {BITS{1'b0}};
         DAC_TRIAL         <= {BITS{1'b0}};
         POS_SAMPLE_SWITCH <= 1'b1;
         NEG_SAMPLE_SWITCH <= 1'b1;
         POWER_DOWN        <= 1'b1;
         BUSY              <= 1'b0;
         RESULT_CODE       <= `SARSEQ_CODE_ZERO;
         CHAIN_MODE        <= 1'b1;
      end else begin
         cnv_d <= cnv_s;
         sck_d <= sck_s;
         case (state)
            ST_ACQ: begin
               if (cnv_rise) begin
                  POS_SAMPLE_SWITCH <= 1'b0;
                  NEG_SAMPLE_SWITCH <= 1'b0;
                  POWER_DOWN        <= 1'b0;
                  BUSY              <= 1'b1;
                  CHAIN_MODE        <= ~msel_s;
                  step              <= {CNT_W{1'b0}};
                  state             <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               // switches are already open; first trial loads msb
               if (step == `SARSEQ_SETTLE_CYC - 1) begin
                  work      <= {BITS{1'b0}};
                  DAC_TRIAL <= `SARSEQ_CODE_MID;
                  step      <= {CNT_W{1'b0}};
                  state     <= ST_TRIAL;
               end else begin
                  step <= step + 5'd1;
               end
            end
            ST_TRIAL: begin
               // convert input ignored here on purpose
               if (step_en) begin
                  // keep the trial bit when the comparator says input is above it
                  if (COMP_HIGH) begin
                     work[BITS-1-step] <= 1'b1;
                  end
                  if (step == BITS - 1) begin
                     state <= ST_DONE;
                  end else begin
                     DAC_TRIAL <= (COMP_HIGH ? DAC_TRIAL : (DAC_TRIAL & ~(`SARSEQ_CODE_MID >> step)))
                                  | (`SARSEQ_CODE_MID >> (step + 5'd1));
                     step <= step + 5'd1;
                  end
               end
            end
            ST_DONE: begin
               // clamp outside the range instead of trusting the comparator
               if (OVER_RANGE)
                  RESULT_CODE <= `SARSEQ_CODE_FULL;
               else if (UNDER_RANGE)
                  RESULT_CODE <= `SARSEQ_CODE_ZERO;
               else
                  RESULT_CODE <= work;
               BUSY              <= 1'b0;
               POS_SAMPLE_SWITCH <= 1'b1;
               NEG_SAMPLE_SWITCH <= 1'b1;
               POWER_DOWN        <= 1'b1;
               DAC_TRIAL         <= {BITS{1'b0}};
               state             <= ST_ACQ;
            end
            default: state <= ST_ACQ;
         endcase
      end
   end

   // ----------------------------------------
   // serial readout
   // ----------------------------------------
   // select mode: drive while convert low; chain mode: drive while convert high
   // limitation: busy start bit and chain pass-through data are not modelled
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         shreg              <= {BITS{1'b0}};
         shcnt              <= {CNT_W{1'b0}};
         SERIAL_RESULT_OUT  <= 1'b0;
         SERIAL_RESULT_OE_N <= 1'b1;
      end else if (BUSY || state != ST_ACQ) begin
         SERIAL_RESULT_OE_N <= 1'b1;
         shcnt              <= {CNT_W{1'b0}};
      end else if ((!CHAIN_MODE && cnv_fall) || (shcnt == 0 && SERIAL_RESULT_OE_N
                   && (CHAIN_MODE ? cnv_s : ~cnv_s) && !cnv_rise && !cnv_fall)) begin
         // load msb once selected and idle; a chain-mode convert rise also
         // starts a conversion, so that frame waits until busy has dropped
         shreg              <= {RESULT_CODE[BITS-2:0], 1'b0};
         SERIAL_RESULT_OUT  <= RESULT_CODE[BITS-1];
         SERIAL_RESULT_OE_N <= 1'b0;
         shcnt              <= 5'd1;
      end else if (CHAIN_MODE ? ~cnv_s : cnv_s) begin
         SERIAL_RESULT_OE_N <= 1'b1; // deselect ends the frame
      end else if (sck_fall && !SERIAL_RESULT_OE_N) begin
         if (shcnt == BITS) begin
            SERIAL_RESULT_OE_N <= 1'b1; // after 16th falling edge
         end else begin
            SERIAL_RESULT_OUT <= shreg[BITS-1];
            shreg             <= {shreg[BITS-2:0], 1'b0};
            shcnt             <= shcnt + 5'd1;
         end
      end
   end
endmodule // sarseq_top
`default_nettype wire

// ### testbench/sarseq_chk.sv
`timescale 1ns/1ps
`default_nettype none
// conversion timing and status checks on the top pins
module sarseq_chk #(parameter BITS = 16) (
   // clock and reset
   input wire logic            SYS_CLK,
   input wire logic            RST,
   // watched outputs
   input wire logic            POS_SAMPLE_SWITCH,
   input wire logic            NEG_SAMPLE_SWITCH,
   input wire logic [BITS-1:0] DAC_TRIAL,
   input wire logic            POWER_DOWN,
   input wire logic            BUSY,
   input wire logic [BITS-1:0] RESULT_CODE,
   input wire logic            CHAIN_MODE,
   input wire logic            SERIAL_RESULT_OE_N
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   AST_SW_OPEN: assert property ($rose(BUSY) |-> !POS_SAMPLE_SWITCH && !NEG_SAMPLE_SWITCH)
      else $error("switch closed at start");
   AST_MSB: assert property ($rose(BUSY) |-> ##2 DAC_TRIAL == 16'h8000)
      else $error("first trial not msb");
   AST_IDLE: assert property ($fell(BUSY) |-> POWER_DOWN && POS_SAMPLE_SWITCH)
      else $error("no power down at end");
   AST_RUN: assert property (BUSY |-> !POWER_DOWN)
      else $error("powered down while busy");
   AST_KEEP: assert property ($rose(BUSY) |-> BUSY[*8])
      else $error("busy dropped early");
   AST_LEN: assert property ($rose(BUSY) |-> ##[60:90] !BUSY)
      else $error("conversion too long");
   AST_WHOLE: assert property ($fell(BUSY) |-> $past(BUSY, 60))
      else $error("conversion cut short");
   AST_HOLD: assert property (!BUSY && !$past(BUSY) |-> $stable(RESULT_CODE))
      else $error("code moved between ends");
   AST_OE: assert property (BUSY |-> SERIAL_RESULT_OE_N)
      else $error("output driven while busy");
   AST_MODE: assert property (BUSY && $past(BUSY) |-> $stable(CHAIN_MODE))
      else $error("mode moved while busy");
endmodule // sarseq_chk
bind sarseq_top sarseq_chk #(.BITS(BITS)) chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .POS_SAMPLE_SWITCH(POS_SAMPLE_SWITCH), .NEG_SAMPLE_SWITCH(NEG_SAMPLE_SWITCH),
   .DAC_TRIAL(DAC_TRIAL), .POWER_DOWN(POWER_DOWN), .BUSY(BUSY), .RESULT_CODE(RESULT_CODE),
   .CHAIN_MODE(CHAIN_MODE), .SERIAL_RESULT_OE_N(SERIAL_RESULT_OE_N));
`default_nettype wire

// ### testbench/sarseq_host.sv
`timescale 1ns/1ps
`default_nettype none
// host reader: clocks 16 bits out, clock still outside frames
module sarseq_host (
   input  wire logic        go,
   input  wire logic        serial_result_out,
   input  wire logic        oe_n,
   output logic             sck,
   output logic [15:0]      word,
   output logic             done
);
   initial begin
      sck = 1'b0;
      done = 1'b0;
      word = 16'h0000;
   end
   // released line reads inverted so a stale level never passes
   always @(posedge go) begin
      done = 1'b0;
      for (int i = 0; i < 16; i++) begin
         #80 word = {word[14:0], oe_n ? ~serial_result_out : serial_result_out};
         sck = 1'b1;
         #80 sck = 1'b0;
      end
      #80 done = 1'b1;
   end
endmodule // sarseq_host
`default_nettype wire

// ### testbench/sarseq_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sarseq_top_test;
   logic        clk, rst, convert_start, mode, sck, comp, over, under, go, serial_result_out, oe_n, sw_p, sw_n, pd, busy, chain, done;
   logic [15:0] ain, dac, code, word;
   int          err_count, n_tests, cyc;
   sarseq_top dut (.SYS_CLK(clk), .RST(rst), .CONVERT_START(convert_start), .MODE_SELECT_INPUT(mode),
      .SERIAL_CLK(sck), .SERIAL_RESULT_OUT(serial_result_out), .SERIAL_RESULT_OE_N(oe_n), .COMP_HIGH(comp),
      .OVER_RANGE(over), .UNDER_RANGE(under), .POS_SAMPLE_SWITCH(sw_p), .NEG_SAMPLE_SWITCH(sw_n),
      .DAC_TRIAL(dac), .POWER_DOWN(pd), .BUSY(busy), .RESULT_CODE(code), .CHAIN_MODE(chain));
   sarseq_host host (.go(go), .serial_result_out(serial_result_out), .oe_n(oe_n), .sck(sck), .word(word), .done(done));
   assign comp = ain >= dac; // ideal comparator
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one conversion; tog wiggles convert mid-run
   task conv_run(input [15:0] a, input m, input tog, input [15:0] exp);
      int i;
      @(negedge clk) convert_start = 1'b0;
      repeat (4) @(negedge clk);
      ain = a;
      mode = m;
      convert_start = 1'b1;
      for (i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
      `CHK(busy, 1'b1)
      `CHK(sw_p, 1'b0)
      `CHK(sw_n, 1'b0)
      if (tog) repeat (6) @(negedge clk) convert_start = ~convert_start;
      for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(code, exp)
      `CHK(sw_p, 1'b1)
      `CHK(pd, 1'b1)
   endtask
   task t_codes;
      logic [15:0] v[7] = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'h8001, 16'hffff, 16'h5a3c};
      foreach (v[k]) conv_run(v[k], 1'b1, 1'b0, v[k]);
      $display("codes done");
   endtask
   task t_range;
      over = 1'b1;
      conv_run(16'h1234, 1'b1, 1'b0, 16'hffff);
      over = 1'b0;
      under = 1'b1;
      conv_run(16'hc000, 1'b1, 1'b0, 16'h0000);
      under = 1'b0;
      $display("range done");
   endtask
   task t_hold;
      conv_run(16'h3c5a, 1'b1, 1'b1, 16'h3c5a);
      ain = 16'h0f0f;
      repeat (30) @(negedge clk);
      `CHK(code, 16'h3c5a)
      $display("hold done");
   endtask
   task t_read;
      int i;
      conv_run(16'ha5c3, 1'b1, 1'b0, 16'ha5c3);
      `CHK(chain, 1'b0)
      convert_start = 1'b0;
      repeat (5) @(negedge clk);
      `CHK(oe_n, 1'b0)
      go = 1'b1;
      @(negedge clk);
      for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
      go = 1'b0;
      `CHK(word, 16'ha5c3)
      `CHK(oe_n, 1'b1)
      conv_run(16'h0100, 1'b0, 1'b0, 16'h0100);
      `CHK(chain, 1'b1)
      // chain mode reads while convert stays high after the conversion
      repeat (5) @(negedge clk);
      `CHK(oe_n, 1'b0)
      go = 1'b1;
      @(negedge clk);
      for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
      go = 1'b0;
      `CHK(word, 16'h0100)
      `CHK(oe_n, 1'b1)
      $display("read done");
   endtask
   initial begin
      {convert_start, mode, over, under, go} = 5'h00;
      ain = 16'h0000;
      rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      t_codes;
      t_range;
      t_hold;
      t_read;
      close_out;
   end
endmodule // sarseq_top_test
`default_nettype wire
